// ### src/hpw_watchdog.sv
`timescale 1ns/1ns
`default_nettype none
`include "hpw_defs.svh"

module hpw_watchdog #(
  parameter logic [`HPW_CNT_W-1:0] BOOT_CYCLES = `HPW_BOOT_CYCLES,
  parameter logic [`HPW_CNT_W-1:0] OFF_CYCLES = `HPW_OFF_CYCLES,
  parameter logic [`HPW_CNT_W-1:0] LOSS_CYCLES = `HPW_LOSS_CYCLES,
  parameter logic [`HPW_CNT_W-1:0] LED_CYCLES = `HPW_LED_CYCLES,
  parameter logic [`HPW_CNT_W-1:0] KICK_PERIOD = `HPW_KICK_PERIOD
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic holdoff_bit,
  output logic host_power_off,
  output logic supervisor_kick_input,
  output logic ext_interrupt_zero,
  output logic capture_clear_n,
  output hpw_pkg::hpw_leds_t test_led_header
);
  hpw_pkg::hpw_state_t state;
  hpw_pkg::hpw_state_t next_state;
  logic capture_n;
  logic capture_n_last;
  logic irq;
  logic [`HPW_CNT_W-1:0] timer;
  logic [`HPW_CNT_W-1:0] next_timer;
  logic [`HPW_CNT_W-1:0] loss;
  logic [`HPW_CNT_W-1:0] next_loss;
  logic [`HPW_CNT_W-1:0] led_cnt;
  logic [`HPW_CNT_W-1:0] next_led_cnt;
  logic [`HPW_CNT_W-1:0] kick_cnt;
  logic [`HPW_CNT_W-1:0] next_kick_cnt;
  logic next_power_off;
  logic next_kick;
  logic next_irq_out;
  logic next_clear_n;
  logic next_led;
  logic led;

  hpw_capture u_capture (
    .clk(clk),
    .resetn(resetn),
    .holdoff_bit(holdoff_bit),
    .clear_n(capture_clear_n),
    .capture_n(capture_n)
  );

  // Falling edge of the inverted capture output is the interrupt
  assign irq = capture_n_last && !capture_n;

  // Mode sequencing, timers and output levels
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_loss = loss;
    next_led_cnt = (led_cnt != '0) ? led_cnt - 1'b1 : led_cnt;
    next_kick_cnt = kick_cnt;
    next_power_off = 1'b0;
    next_kick = 1'b0;
    next_irq_out = irq;
    // Outside service, a captured pulse is still cleared and shown
    next_clear_n = !(ext_interrupt_zero
      || (!capture_clear_n && !capture_n));
    if (ext_interrupt_zero) begin
      next_led_cnt = LED_CYCLES;
    end
    // Kick runs through the whole normal loop, service included
    if (state == hpw_pkg::HPW_WATCH || state == hpw_pkg::HPW_SERVICE
        || state == hpw_pkg::HPW_CLEARING) begin
      if (kick_cnt >= KICK_PERIOD - 1'b1) begin
        next_kick_cnt = '0;
      end else begin
        next_kick_cnt = kick_cnt + 1'b1;
      end
      next_kick = (kick_cnt < `HPW_KICK_CYCLES);
    end
    case (state)
      hpw_pkg::HPW_BOOT: begin
        // Host boots; pulses not checked yet
        if (timer >= BOOT_CYCLES - 1'b1) begin
          next_state = hpw_pkg::HPW_WATCH;
          next_timer = '0;
          next_loss = '0;
        end else begin
          next_timer = timer + 1'b1;
        end
      end
      hpw_pkg::HPW_WATCH: begin
        // Normal loop; power off waits for a running kick to end
        if (irq) begin
          next_state = hpw_pkg::HPW_SERVICE;
        end else if (loss >= LOSS_CYCLES - 1'b1
            && kick_cnt >= `HPW_KICK_CYCLES) begin
          next_state = hpw_pkg::HPW_POWER_OFF;
          next_timer = '0;
          next_power_off = 1'b1;
        end else begin
          next_loss = loss + 1'b1;
        end
      end
      hpw_pkg::HPW_SERVICE: begin
        // Confirm pulse, start clear strobe
        next_loss = '0;
        next_led_cnt = LED_CYCLES;
        next_clear_n = 1'b0;
        next_timer = '0;
        next_state = hpw_pkg::HPW_CLEARING;
      end
      hpw_pkg::HPW_CLEARING: begin
        // Hold clear low, then release high
        // Held low until the flop has really let go
        if (timer >= `HPW_CLEAR_CYCLES - 1 && capture_n) begin
          next_state = hpw_pkg::HPW_WATCH;
          next_timer = '0;
        end else begin
          next_clear_n = 1'b0;
          next_timer = timer + 1'b1;
        end
      end
      hpw_pkg::HPW_POWER_OFF: begin
        // Host power disconnected, then reboot wait
        if (timer >= OFF_CYCLES - 1'b1) begin
          next_state = hpw_pkg::HPW_BOOT;
          next_timer = '0;
        end else begin
          next_power_off = 1'b1;
          next_timer = timer + 1'b1;
        end
      end
      default: begin
        next_state = hpw_pkg::HPW_BOOT;
        next_timer = '0;
      end
    endcase
    next_led = (next_led_cnt != '0);
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= hpw_pkg::HPW_BOOT;
      timer <= '0;
      loss <= '0;
      led_cnt <= '0;
      kick_cnt <= '0;
      host_power_off <= 1'b0;
      supervisor_kick_input <= 1'b0;
      ext_interrupt_zero <= 1'b0;
      capture_clear_n <= 1'b0;
      capture_n_last <= 1'b1;
      led <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      loss <= next_loss;
      led_cnt <= next_led_cnt;
      kick_cnt <= next_kick_cnt;
      host_power_off <= next_power_off;
      supervisor_kick_input <= next_kick;
      ext_interrupt_zero <= next_irq_out;
      capture_clear_n <= next_clear_n;
      capture_n_last <= capture_n;
      led <= next_led;
    end
  end

  // Spare LEDs carry nothing
  assign test_led_header.confirm_test_led = led;
  assign test_led_header.spare_test_led_a = 1'b0;
  assign test_led_header.spare_test_led_b = 1'b0;
endmodule
`default_nettype wire

// ### src/hpw_defs.svh
`ifndef HPW_DEFS_SVH
`define HPW_DEFS_SVH

// Clock rate and documented times
`define HPW_CLK_HZ 10000000
`define HPW_PULSE_RATE_HZ 2
`define HPW_OFF_TIME_S 10
`define HPW_BOOT_WAIT_S 60
// Silence allowed before hold-off is declared lost (two pulse periods)
`define HPW_LOSS_PERIODS 4
// Cycles for counts
`define HPW_OFF_CYCLES (`HPW_OFF_TIME_S * `HPW_CLK_HZ)
`define HPW_BOOT_CYCLES (`HPW_BOOT_WAIT_S * `HPW_CLK_HZ)
`define HPW_LOSS_CYCLES (`HPW_LOSS_PERIODS * `HPW_CLK_HZ / (2 * `HPW_PULSE_RATE_HZ))
// Short action widths
`define HPW_CLEAR_CYCLES 2
`define HPW_KICK_CYCLES 2
`define HPW_LED_CYCLES 1000000
`define HPW_KICK_PERIOD 1000
`define HPW_CNT_W 32

`endif

// ### src/hpw_pkg.sv
`default_nettype none
package hpw_pkg;
  typedef enum logic [2:0] {
    HPW_BOOT = 3'b000,
    HPW_WATCH = 3'b001,
    HPW_SERVICE = 3'b010,
    HPW_CLEARING = 3'b011,
    HPW_POWER_OFF = 3'b100
  } hpw_state_t;

  // Indicator outputs grouped together
  typedef struct packed {
    logic confirm_test_led;
    logic spare_test_led_a;
    logic spare_test_led_b;
  } hpw_leds_t;
endpackage
`default_nettype wire

// ### src/hpw_capture.sv
`timescale 1ns/1ns
`default_nettype none
`include "hpw_defs.svh"

// Edge-capture flip-flop on the synchronised hold-off bit
module hpw_capture (
  input wire logic clk,
  input wire logic resetn,
  input wire logic holdoff_bit,
  input wire logic clear_n,
  output logic capture_n
);
  logic sync1;
  logic sync2;
  logic last;
  logic captured;
  logic next_sync1;
  logic next_sync2;
  logic next_last;
  logic next_captured;

  // Rising edge sets, clear low rearms; an edge while set merges
  always_comb begin
    next_sync1 = holdoff_bit;
    next_sync2 = sync1;
    next_last = sync2;
    next_captured = captured;
    if (sync2 && !last) begin
      next_captured = 1'b1;
    end else if (!clear_n) begin
      next_captured = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      captured <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      last <= next_last;
      captured <= next_captured;
    end
  end

  assign capture_n = ~captured;
endmodule
`default_nettype wire

// ### testbench/hpw_wd_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Pin-level timing checks for the hold-off watchdog
module hpw_wd_assertions #(
  parameter logic [31:0] OFF_CYCLES = 32'h14
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic holdoff_bit,
  input wire logic host_power_off,
  input wire logic supervisor_kick_input,
  input wire logic ext_interrupt_zero,
  input wire logic capture_clear_n,
  input wire hpw_pkg::hpw_leds_t test_led_header
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Interrupt and clear strobe shapes
  a_irq_one_cycle: assert property (ext_interrupt_zero |=> !ext_interrupt_zero)
    else $error("interrupt pulse too long");
  a_clear_cause: assert property ($fell(capture_clear_n) |-> $past(ext_interrupt_zero))
    else $error("clear without interrupt");
  a_clear_width: assert property ($fell(capture_clear_n)
    |=> !capture_clear_n ##1 capture_clear_n)
    else $error("clear strobe width wrong");
  // Indicators
  a_led_flash: assert property ($fell(capture_clear_n)
    |=> test_led_header.confirm_test_led)
    else $error("confirm led not lit");
  a_spares_dark: assert property (!test_led_header.spare_test_led_a
    && !test_led_header.spare_test_led_b)
    else $error("spare led lit");
  // Supervisor kick
  a_kick_width: assert property ($rose(supervisor_kick_input)
    |=> supervisor_kick_input ##1 !supervisor_kick_input)
    else $error("kick width wrong");
  a_kick_powered: assert property (supervisor_kick_input |-> !host_power_off)
    else $error("kick while host off");
  // Host power off span
  a_off_length: assert property ($fell(host_power_off)
    |-> $past(host_power_off, OFF_CYCLES))
    else $error("power off too short");
  c_edge: cover property ($rose(holdoff_bit));
  c_irq: cover property (ext_interrupt_zero);
  c_off: cover property ($rose(host_power_off));
endmodule
bind hpw_watchdog hpw_wd_assertions #(.OFF_CYCLES(OFF_CYCLES)) u_chk (.*);
`default_nettype wire

// ### testbench/hpw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host printer port: hold-off bit toggling while its program runs
module hpw_host_model #(parameter int PERIOD = 50) (
  input wire logic clk,
  input wire logic en,
  output logic holdoff_bit
);
  int cnt = 0;
  initial holdoff_bit = 1'b0;
  // Square wave, one rising edge per period
  always @(negedge clk) begin
    cnt <= (en && cnt < PERIOD - 1) ? cnt + 1 : 0;
    holdoff_bit <= en && cnt >= PERIOD / 2;
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, resetn = 0, en = 0, man = 0, mbit = 0;
  logic hbit, off, kick, irq, clr_n;
  hpw_pkg::hpw_leds_t leds;
  int fails = 0, num_checks = 0, nirq = 0, k;
  int nkick = 0, kk, d;
  logic kick_q = 0;
  typedef struct {logic en; int n; logic off; int ints; int kicks;} row_t;
  row_t rows[3] = '{'{0, 40, 0, 0, 0}, '{1, 400, 0, 8, 39},
    '{0, 30, 0, 0, 3}};
  hpw_host_model host (.clk(clk), .en(en), .holdoff_bit(hbit));
  hpw_watchdog #(.BOOT_CYCLES(32'h32), .OFF_CYCLES(32'h14),
    .LOSS_CYCLES(32'h64), .LED_CYCLES(32'h5), .KICK_PERIOD(32'ha)) dut (
    .clk(clk), .resetn(resetn), .holdoff_bit(man ? mbit : hbit),
    .host_power_off(off), .supervisor_kick_input(kick),
    .ext_interrupt_zero(irq), .capture_clear_n(clr_n),
    .test_led_header(leds));
  initial forever #50 clk = ~clk;
  // Interrupt pulse counter
  always @(posedge clk) if (irq === 1'b1) nirq++;
  // Kick rising edge counter
  always @(posedge clk) begin
    if (kick === 1'b1 && kick_q !== 1'b1) nkick++;
    kick_q <= kick;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #300000;
    fails++;
    end_of_test;
  end
  initial begin
    cyc(8);
    chk(off === 1'b0 && clr_n === 1'b0 && leds === '0, "reset");
    $display("reset done");
    resetn <= 1'b1;
    // Boot wait, steady pulsing, short silence
    foreach (rows[i]) begin
      k = nirq;
      kk = nkick;
      en <= rows[i].en;
      cyc(rows[i].n);
      chk(off === rows[i].off && nirq - k == rows[i].ints, "row");
      d = nkick - kk;
      if (rows[i].kicks == 0) chk(d == 0, "kicks in boot");
      else chk(d >= rows[i].kicks - 1 && d <= rows[i].kicks + 1, "kicks");
      $display("row %0d done", i);
    end
    // Lost pulses: power off span
    k = 0;
    while (off !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    k = 0;
    while (off === 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    chk(k == 20, "power off span");
    $display("power cycle done");
    // Second edge before clear merges
    cyc(60);
    man <= 1'b1;
    k = nirq;
    mbit <= 1'b1;
    cyc(1);
    mbit <= 1'b0;
    cyc(1);
    mbit <= 1'b1;
    cyc(4);
    chk(leds.confirm_test_led === 1'b1, "confirm led");
    chk(leds.spare_test_led_a === 1'b0 && leds.spare_test_led_b === 1'b0,
      "spare leds");
    cyc(16);
    chk(nirq - k == 1, "merged edges");
    $display("merge done");
    // Mid-run reset, then a pulse in boot must not lock out capture
    man <= 1'b0;
    resetn <= 1'b0;
    cyc(2);
    chk(off === 1'b0 && kick === 1'b0 && irq === 1'b0 && clr_n === 1'b0,
      "mid reset");
    resetn <= 1'b1;
    cyc(2);
    chk(clr_n === 1'b1 && off === 1'b0 && kick === 1'b0, "after reset");
    man <= 1'b1;
    mbit <= 1'b0;
    cyc(3);
    mbit <= 1'b1;
    cyc(60);
    k = nirq;
    mbit <= 1'b0;
    cyc(2);
    mbit <= 1'b1;
    cyc(10);
    chk(nirq - k == 1, "pulse after boot");
    $display("boot pulse done");
    end_of_test;
  end
endmodule
`default_nettype wire
